// [core/ssrp_regmem.sv]
`timescale 1ns/1ps
module ssrp_regmem #(
   parameter int unsigned AW = 8,
   parameter int unsigned DW = 8
) (
   input  wire logic          clk_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [DW-1:0] wdata_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic      [DW-1:0] rdata_out
);
   // Plain storage has no reset; locations read unknown until first written.
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
      rdata_out <= mem[raddr_in];
   end
endmodule : ssrp_regmem

// [core/ssrp_top.sv]
`timescale 1ns/1ps
module ssrp_top (
   input  wire logic                            clk_sys_in,
   input  wire logic                            reset_in,
   input  wire logic                            link_clk_in,
   input  wire logic                            scl_in,
   input  wire logic                            sda_in,
   output logic                                 sda_out,
   output logic                                 sda_oe_out,
   input  wire logic                            addr_strap_bit0_in,
   input  wire logic                            addr_strap_bit1_in,
   input  wire logic                            chassis_intrusion_in,
   input  wire logic [ssrp_pkg::EVENT_COUNT-1:0] event_in,
   output logic      [ssrp_pkg::EVENT_COUNT-1:0] int_masked_out,
   output logic                                 intrusion_latched_out,
   output logic      [ssrp_pkg::TEMP_CFG_BITS-1:0] temp_int_mode_out
);
   import ssrp_pkg::*;

   // Link-clock domain: bus sampling, framing and the target state machine.
   logic        link_rst_a;
   logic        link_rst;
   logic        scl_m, scl_s, scl_q;
   logic        sda_m, sda_s, sda_q;
   logic [1:0]  strap_m, strap_s;
   logic [1:0]  cap_cnt;
   logic        strap_caught;
   logic [1:0]  strap_val;
   logic        rsp_m, rsp_s, rsp_q;
   logic        rsp_tgl;
   logic [7:0]  rsp_data;

   ssrp_state_e state, next_state;
   logic [3:0]  bit_cnt, next_cnt;
   logic [7:0]  shreg, next_shreg;
   logic [1:0]  byte_idx, next_idx;
   logic [7:0]  ptr, next_ptr;
   logic [4:0]  dev_upper, next_upper;
   logic        sda_oe, next_oe;
   logic [7:0]  tx, next_tx;
   logic        rw, next_rw;
   logic        rd_acked, next_acked;
   ssrp_req_s   req, next_req;
   logic        req_tgl, next_req_tgl;

   // The reset is taken at once but released on the link clock.
   always_ff @(posedge link_clk_in or posedge reset_in) begin
      if (reset_in) begin
         link_rst_a <= 1'b1;
         link_rst   <= 1'b1;
      end else begin
         link_rst_a <= 1'b0;
         link_rst   <= link_rst_a;
      end
   end

   always_ff @(posedge link_clk_in or posedge link_rst) begin
      if (link_rst) begin
         {scl_m, scl_s, scl_q} <= 3'h7;
         {sda_m, sda_s, sda_q} <= 3'h7;
         strap_m               <= 2'h0;
         strap_s               <= 2'h0;
         {rsp_m, rsp_s, rsp_q} <= 3'h0;
      end else begin
         {scl_m, scl_s, scl_q} <= {scl_in, scl_m, scl_s};
         {sda_m, sda_s, sda_q} <= {sda_in, sda_m, sda_s};
         strap_m               <= {addr_strap_bit1_in, addr_strap_bit0_in};
         strap_s               <= strap_m;
         {rsp_m, rsp_s, rsp_q} <= {rsp_tgl, rsp_m, rsp_s};
      end
   end

   // Straps are caught once, a few cycles after release, so the synchroniser has settled.
   always_ff @(posedge link_clk_in or posedge link_rst) begin
      if (link_rst) begin
         cap_cnt      <= 2'h0;
         strap_caught <= 1'b0;
         strap_val    <= 2'h0;
      end else if (!strap_caught) begin
         if (cap_cnt == STRAP_SETTLE) begin
            strap_val    <= strap_s; // R1 R2
            strap_caught <= 1'b1;
         end else begin
            cap_cnt <= cap_cnt + 2'h1;
         end
      end
   end

   wire       scl_rise   = scl_s & ~scl_q;
   wire       scl_fall   = ~scl_s & scl_q;
   wire       start_det  = scl_s & scl_q & sda_q & ~sda_s;
   wire       stop_det   = scl_s & scl_q & ~sda_q & sda_s;
   wire       byte_done  = (bit_cnt == BITS_PER_BYTE);
   wire       rsp_seen   = rsp_s ^ rsp_q;
   wire [6:0] dev_addr   = {dev_upper, strap_val};
   wire       addr_match = strap_caught & (shreg[7:1] == dev_addr);
   wire [2:0] tx_index   = 3'(MSB_INDEX - bit_cnt);
   wire       ptr_local  = (ptr == REG_SERIAL_ADDR);

   always_comb begin
      next_state   = state;
      next_cnt     = bit_cnt;
      next_shreg   = shreg;
      next_idx     = byte_idx;
      next_ptr     = ptr;
      next_upper   = dev_upper;
      next_oe      = sda_oe;
      next_tx      = rsp_seen ? rsp_data : tx;
      next_rw      = rw;
      next_acked   = rd_acked;
      next_req     = req;
      next_req_tgl = req_tgl;
      if (scl_rise) begin
         next_shreg = {shreg[6:0], sda_s}; // R5 R8
         if (!byte_done) begin
            next_cnt = bit_cnt + 4'h1;
         end
      end
      case (state)
         ST_ADDR: begin
            if (scl_fall && byte_done) begin
               if (addr_match) begin // R4 R6
                  next_state = ST_ADDR_ACK;
                  next_oe    = 1'b1;
                  next_rw    = shreg[0]; // R7 R12
                  if (shreg[0] && ptr_local) begin
                     next_tx = {1'b0, dev_addr};
                  end else if (shreg[0]) begin
                     next_req     = '{write: 1'b0, addr: ptr, data: 8'h00}; // R16
                     next_req_tgl = ~req_tgl;
                  end
               end else begin
                  next_state = ST_IGNORE; // R6
               end
            end
         end
         ST_ADDR_ACK: begin
            if (scl_fall) begin
               next_cnt = 4'h0;
               next_idx = 2'h0;
               if (rw) begin
                  next_state = ST_RD_BYTE;
                  next_oe    = ~tx[7]; // R20
               end else begin
                  next_state = ST_WR_BYTE;
                  next_oe    = 1'b0;
               end
            end
         end
         ST_WR_BYTE: begin
            if (scl_fall && byte_done) begin
               if (byte_idx == 2'h0) begin
                  next_ptr   = shreg; // R13 R15
                  next_state = ST_WR_ACK;
                  next_oe    = 1'b1;
               end else if (byte_idx == 2'h1) begin
                  if (ptr_local) begin
                     next_upper = shreg[6:2]; // R3 R4
                  end else begin
                     next_req     = '{write: 1'b1, addr: ptr, data: shreg}; // R14
                     next_req_tgl = ~req_tgl;
                  end
                  next_state = ST_WR_ACK;
                  next_oe    = 1'b1;
               end else begin
                  next_state = ST_IGNORE;
               end
            end
         end
         ST_WR_ACK: begin
            if (scl_fall) begin
               next_oe    = 1'b0;
               next_cnt   = 4'h0;
               next_state = ST_WR_BYTE;
               next_idx   = (byte_idx == 2'h0) ? 2'h1 : 2'h2;
            end
         end
         ST_RD_BYTE: begin
            if (scl_fall && byte_done) begin
               next_oe    = 1'b0; // R20
               next_acked = 1'b0;
               next_state = ST_RD_ACK;
            end else if (scl_fall) begin
               next_oe = ~tx[tx_index]; // R20 R9
            end
         end
         ST_RD_ACK: begin
            if (scl_rise && sda_s) begin
               next_state = ST_IGNORE; // R11
            end else if (scl_rise) begin
               next_acked = 1'b1;
            end else if (scl_fall && rd_acked) begin
               next_state = ST_RD_BYTE;
               next_cnt   = 4'h0;
               next_oe    = ~tx[7];
            end
         end
         default: begin
         end
      endcase
      if (start_det) begin
         next_state = ST_ADDR; // R5 R12
         next_cnt   = 4'h0;
         next_oe    = 1'b0;
      end else if (stop_det) begin
         next_state = ST_IDLE; // R9 R10 R11
         next_oe    = 1'b0;
      end
   end

   always_ff @(posedge link_clk_in or posedge link_rst) begin
      if (link_rst) begin
         state     <= ST_IDLE;
         bit_cnt   <= 4'h0;
         shreg     <= 8'h00;
         byte_idx  <= 2'h0;
         ptr       <= 8'h00;
         dev_upper <= DEV_ADDR_UPPER_RST; // R1
         sda_oe    <= 1'b0;
         tx        <= 8'h00;
         rw        <= 1'b0;
         rd_acked  <= 1'b0;
         req       <= '0;
         req_tgl   <= 1'b0;
      end else begin
         state     <= next_state;
         bit_cnt   <= next_cnt;
         shreg     <= next_shreg;
         byte_idx  <= next_idx;
         ptr       <= next_ptr;
         dev_upper <= next_upper;
         sda_oe    <= next_oe;
         tx        <= next_tx;
         rw        <= next_rw;
         rd_acked  <= next_acked;
         req       <= next_req;
         req_tgl   <= next_req_tgl;
      end
   end

   // The pin is open drain: only a low level is ever driven.
   assign sda_out    = 1'b0;
   assign sda_oe_out = sda_oe;

   a_start_addr : assert property (@(posedge link_clk_in) disable iff (link_rst) // R5
      start_det |=> (state == ST_ADDR) && (bit_cnt == 4'h0) && !sda_oe)
      else $error("start did not begin an address phase");
   a_stop_idle : assert property (@(posedge link_clk_in) disable iff (link_rst) // R9
      (stop_det && !start_det) |=> (state == ST_IDLE) && !sda_oe)
      else $error("stop did not end the transfer");
   a_ack_on_match : assert property (@(posedge link_clk_in) disable iff (link_rst) // R6
      (state == ST_ADDR && scl_fall && byte_done && addr_match && !start_det && !stop_det)
      |=> sda_oe && (state == ST_ADDR_ACK))
      else $error("matching address not acknowledged");
   a_mismatch_idle : assert property (@(posedge link_clk_in) disable iff (link_rst) // R6
      (state == ST_ADDR && scl_fall && byte_done && !addr_match && !start_det && !stop_det)
      |=> (state == ST_IGNORE) && !sda_oe)
      else $error("foreign address was answered");
   a_ptr_load : assert property (@(posedge link_clk_in) disable iff (link_rst) // R13
      (state == ST_WR_BYTE && byte_idx == 2'h0 && scl_fall && byte_done)
      |=> ptr == $past(shreg))
      else $error("first write byte not loaded into pointer");
   a_data_request : assert property (@(posedge link_clk_in) disable iff (link_rst) // R14
      (state == ST_WR_BYTE && byte_idx == 2'h1 && scl_fall && byte_done && !ptr_local)
      |=> (req_tgl != $past(req_tgl)) && req.write && (req.data == $past(shreg)))
      else $error("second write byte not passed on");
   a_release_sda : assert property (@(posedge link_clk_in) disable iff (link_rst) // R20
      (state == ST_RD_BYTE && scl_fall && byte_done) |=> !sda_oe ##1 !sda_oe)
      else $error("sda held during master acknowledge");
   a_strap_caught : assert property (@(posedge link_clk_in) disable iff (link_rst) // R1
      $rose(strap_caught) |-> (strap_val == $past(strap_s)) && (dev_upper == DEV_ADDR_UPPER_RST))
      else $error("power-up address wrong");
   a_low_bits_kept : assert property (@(posedge link_clk_in) disable iff (link_rst) // R3
      $past(strap_caught) |-> $stable(strap_val))
      else $error("strap address bits changed");

   // System-clock domain: register file, event status and the intrusion latch.
   logic                   req_m, req_s, req_q;
   logic                   intr_m, intr_s, intr_q;
   logic [EVENT_COUNT-1:0] status;
   logic [EVENT_COUNT-1:0] mask;
   logic [TEMP_CFG_BITS-1:0] temp_cfg;
   logic                   intrusion;
   logic                   rd_pend;
   logic                   rd_use_mem;
   logic [7:0]             rd_special;
   logic [7:0]             mem_rdata;

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         {req_m, req_s, req_q}    <= 3'h0;
         {intr_m, intr_s, intr_q} <= 3'h0;
      end else begin
         {req_m, req_s, req_q}    <= {req_tgl, req_m, req_s};
         {intr_m, intr_s, intr_q} <= {chassis_intrusion_in, intr_m, intr_s};
      end
   end

   // The request word is held still by the link side until its next toggle, so it is
   // safe to read once the synchronised toggle has been seen.
   wire       req_seen  = req_s ^ req_q;
   wire       do_write  = req_seen & req.write;
   wire       do_read   = req_seen & ~req.write;
   wire       hit_st1   = (req.addr == REG_INT_STATUS1);
   wire       hit_st2   = (req.addr == REG_INT_STATUS2);
   wire       hit_mk1   = (req.addr == REG_INT_MASK1);
   wire       hit_mk2   = (req.addr == REG_INT_MASK2);
   wire       hit_temp  = (req.addr == REG_TEMP_CFG);
   wire       hit_intr  = (req.addr == REG_INTR_CLEAR);
   wire       hit_saddr = (req.addr == REG_SERIAL_ADDR);
   wire       special   = hit_st1 | hit_st2 | hit_mk1 | hit_mk2 | hit_temp | hit_intr | hit_saddr;
   wire       mem_we    = do_write & ~special;
   wire       intr_rise = intr_s & ~intr_q;
   wire       intr_clr  = do_write & hit_intr;
   wire [EVENT_COUNT-1:0] status_clr = {{8{do_read & hit_st2}}, {8{do_read & hit_st1}}};
   wire [7:0] reg_rdata =
      hit_st1  ? status[7:0] :
      hit_st2  ? status[15:8] :
      hit_mk1  ? mask[7:0] :
      hit_mk2  ? mask[15:8] :
      hit_temp ? {5'h00, temp_cfg} :
      hit_intr ? {7'h00, intrusion} :
      8'h00;

   ssrp_regmem #(
      .AW (8),
      .DW (8)
   ) u_regmem (
      .clk_in    (clk_sys_in),
      .we_in     (mem_we), // R14 R15
      .waddr_in  (req.addr),
      .wdata_in  (req.data),
      .raddr_in  (req.addr),
      .rdata_out (mem_rdata)
   );

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         status    <= '0;
         intrusion <= 1'b0;
      end else begin
         status    <= (status & ~status_clr) | event_in; // R18
         intrusion <= (intrusion & ~intr_clr) | intr_rise; // R17
      end
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         mask     <= INT_MASK_RST;
         temp_cfg <= TEMP_CFG_RST;
      end else if (do_write) begin
         if (hit_mk1) begin
            mask[7:0] <= req.data; // R18
         end else if (hit_mk2) begin
            mask[15:8] <= req.data;
         end else if (hit_temp) begin
            temp_cfg <= req.data[TEMP_CFG_BITS-1:0]; // R19
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         rd_pend    <= 1'b0;
         rd_use_mem <= 1'b0;
         rd_special <= 8'h00;
         rsp_data   <= 8'h00;
         rsp_tgl    <= 1'b0;
      end else begin
         rd_pend <= do_read;
         if (do_read) begin
            rd_use_mem <= ~special;
            rd_special <= reg_rdata;
         end
         if (rd_pend) begin
            rsp_data <= rd_use_mem ? mem_rdata : rd_special; // R16
            rsp_tgl  <= ~rsp_tgl;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         int_masked_out        <= '0;
         intrusion_latched_out <= 1'b0;
      end else begin
         int_masked_out        <= status & ~mask; // R18
         intrusion_latched_out <= intrusion;
      end
   end

   assign temp_int_mode_out = temp_cfg; // R19

   a_intr_latch : assert property (@(posedge clk_sys_in) disable iff (reset_in) // R17
      intr_rise |=> intrusion ##1 intrusion_latched_out)
      else $error("intrusion event not latched");
   a_intr_clear : assert property (@(posedge clk_sys_in) disable iff (reset_in) // R17
      (intr_clr && !intr_rise) |=> !intrusion)
      else $error("intrusion clear ignored");
   a_status_sticky : assert property (@(posedge clk_sys_in) disable iff (reset_in) // R18
      (|event_in) |=> ((status & $past(event_in)) == $past(event_in)))
      else $error("interrupt event lost");
   a_mask_gate : assert property (@(posedge clk_sys_in) disable iff (reset_in) // R18
      ##1 (int_masked_out == ($past(status) & ~$past(mask))))
      else $error("masked status wrong");
   a_temp_mode : assert property (@(posedge clk_sys_in) disable iff (reset_in) // R19
      (do_write && hit_temp) |=> temp_int_mode_out == $past(req.data[2:0]))
      else $error("temperature mode not taken");
   a_read_reply : assert property (@(posedge clk_sys_in) disable iff (reset_in) // R16
      do_read |=> ##1 (rsp_tgl != $past(rsp_tgl, 2)))
      else $error("read request unanswered");
endmodule : ssrp_top

// [include/ssrp_pkg.sv]
// Notes on behaviour
// [R1] At power-up the address is 01011 above the two strap bits.
// [R2] Open straps read zero, so the default address is 0101100.
// [R3] A written address word replaces the five upper bits; strap bits stay.
// [R4] After reprogramming only the new address is answered until changed or reset.
// [R5] START is SDA falling with SCL high; seven address bits MSB first, then direction.
// [R6] On address match drive SDA low for the ninth clock; otherwise stay idle.
// [R7] Direction bit 0 means master writes; 1 means master reads.
// [R8] Each byte is eight data clocks plus one acknowledge clock.
// [R9] SDA changes only while SCL is low; SDA rising with SCL high is STOP.
// [R10] The master ends a write with STOP during the tenth clock.
// [R11] The master ends a read with not-acknowledge, then STOP.
// [R12] Direction is fixed per transfer; changing it needs a new START.
// [R13] The first written byte always loads the register address pointer.
// [R14] A second written byte is stored into the register the pointer selects.
// [R15] A pointer-only write changes the pointer and no data register.
// [R16] A read returns the pointed register; the pointer persists between transfers.
// [R17] Intrusion events latch; writing the intrusion-clear register clears the latch.
// [R18] Each interrupt source has a status bit and a mask bit.
// [R19] Three low bits of the temperature configuration register set temperature interrupt mode.
// [R20] Read bytes go out MSB first; SDA is released for the master's acknowledge.
package ssrp_pkg;
   localparam logic [4:0] DEV_ADDR_UPPER_RST = 5'h0b;
   localparam logic [3:0] BITS_PER_BYTE      = 4'h8;
   localparam logic [3:0] MSB_INDEX          = 4'h7;
   localparam logic [1:0] STRAP_SETTLE       = 2'h3;
   localparam int unsigned EVENT_COUNT       = 16;
   localparam int unsigned TEMP_CFG_BITS     = 3;
   localparam logic [7:0] REG_INT_STATUS1    = 8'h41;
   localparam logic [7:0] REG_INT_STATUS2    = 8'h42;
   localparam logic [7:0] REG_INT_MASK1      = 8'h43;
   localparam logic [7:0] REG_INT_MASK2      = 8'h44;
   localparam logic [7:0] REG_INTR_CLEAR     = 8'h46;
   localparam logic [7:0] REG_SERIAL_ADDR    = 8'h48;
   localparam logic [7:0] REG_TEMP_CFG       = 8'h4b;
   localparam logic [15:0] INT_MASK_RST      = 16'h0000;
   localparam logic [2:0] TEMP_CFG_RST       = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ADDR     = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_WR_BYTE  = 3'b011,
      ST_WR_ACK   = 3'b100,
      ST_RD_BYTE  = 3'b101,
      ST_RD_ACK   = 3'b110,
      ST_IGNORE   = 3'b111
   } ssrp_state_e;

   typedef struct packed {
      logic       write;
      logic [7:0] addr;
      logic [7:0] data;
   } ssrp_req_s;
endpackage : ssrp_pkg

// [verification/ssrp_master_model.sv]
`timescale 1ns/1ps
module ssrp_master_model (
   output logic      scl_out,
   output logic      sda_oe_out,
   input  wire logic sda_in
);
   // A 500 ns phase keeps both bus phases well above the target's oversampling minimum.
   localparam int HALF = 500;
   localparam int QTR  = 250;

   initial begin
      scl_out    = 1'b1;
      sda_oe_out = 1'b0;
   end

   task automatic start_cond();
      #HALF sda_oe_out = 1'b1;
      #HALF scl_out = 1'b0;
   endtask : start_cond

   task automatic xfer_bit(input logic b, output logic s);
      #QTR sda_oe_out = ~b;
      #QTR scl_out = 1'b1;
      #QTR s = sda_in;
      #QTR scl_out = 1'b0;
   endtask : xfer_bit

   // The ninth slot drives a9 (1 releases the wire) and returns the level seen there.
   task automatic xfer_byte(input logic [7:0] tx, input logic a9, output logic [7:0] rx,
                            output logic s9);
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(tx[i], rx[i]);
      end
      xfer_bit(a9, s9);
   endtask : xfer_byte

   task automatic stop_cond();
      #QTR sda_oe_out = 1'b1;
      #QTR scl_out = 1'b1;
      #HALF sda_oe_out = 1'b0;
      #HALF;
   endtask : stop_cond
endmodule : ssrp_master_model

// [verification/test_smbus_slave_register_port.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("[ERR] %s expected %h seen %h", nm, exp, got); \
      end \
   end

module test_smbus_slave_register_port;
   import ssrp_pkg::*;
   logic        clk_sys_in  = 1'b0;
   logic        link_clk_in = 1'b0;
   logic        reset_in    = 1'b1;
   logic        strap0      = 1'b0;
   logic        strap1      = 1'b0;
   logic        intrusion   = 1'b0;
   logic [15:0] event_in    = 16'h0000;
   logic [15:0] int_masked;
   logic        latched;
   logic [2:0]  temp_mode;
   logic        scl;
   logic        m_oe;
   logic        sda_oe;
   logic        sda_lvl;
   wire         sda_wire;
   logic        a;
   logic [7:0]  d;
   int          fail_count  = 0;
   int          comparisons = 0;

   always #20 clk_sys_in = ~clk_sys_in;
   always #15 link_clk_in = ~link_clk_in;

   // Open-drain bus with a pull-up: low whenever either party pulls.
   assign sda_wire = ~((sda_oe & ~sda_lvl) | m_oe);

   ssrp_top dut_u (
      .clk_sys_in           (clk_sys_in),
      .reset_in             (reset_in),
      .link_clk_in          (link_clk_in),
      .scl_in               (scl),
      .sda_in               (sda_wire),
      .sda_out              (sda_lvl),
      .sda_oe_out           (sda_oe),
      .addr_strap_bit0_in   (strap0),
      .addr_strap_bit1_in   (strap1),
      .chassis_intrusion_in (intrusion),
      .event_in             (event_in),
      .int_masked_out       (int_masked),
      .intrusion_latched_out(latched),
      .temp_int_mode_out    (temp_mode)
   );

   ssrp_master_model m_u (
      .scl_out   (scl),
      .sda_oe_out(m_oe),
      .sda_in    (sda_wire)
   );

   task automatic summarize();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   task automatic sys_step();
      @(posedge clk_sys_in);
      #1;
   endtask : sys_step

   task automatic do_reset(input logic [1:0] straps);
      sys_step();
      reset_in = 1'b1;
      {strap1, strap0} = straps;
      repeat (10) sys_step();
      reset_in = 1'b0;
      // Straps are captured a few link clocks after release; no bus traffic before then.
      repeat (20) sys_step();
   endtask : do_reset

   task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data,
                     input logic with_data, output logic ack);
      logic [7:0] rx;
      logic       s;
      m_u.start_cond();
      m_u.xfer_byte({dev, 1'b0}, 1'b1, rx, s);
      ack = ~s;
      if (ack) begin
         m_u.xfer_byte(ptr, 1'b1, rx, s);
         if (with_data) m_u.xfer_byte(data, 1'b1, rx, s);
      end
      m_u.stop_cond();
      #2000;
   endtask : wr

   task automatic rd(input logic [6:0] dev, output logic [7:0] data, output logic ack);
      logic s;
      m_u.start_cond();
      m_u.xfer_byte({dev, 1'b1}, 1'b1, data, s);
      ack = ~s;
      m_u.xfer_byte(8'hff, 1'b1, data, s);
      m_u.stop_cond();
      #2000;
   endtask : rd

   task automatic t_default_addr();
      wr(7'h2c, REG_INT_MASK1, 8'h5a, 1'b1, a);
      `CHK("ack default", 1'b1, a)
      wr(7'h2d, REG_INT_MASK1, 8'h00, 1'b1, a);
      `CHK("ack other", 1'b0, a)
      wr(7'h2c, REG_INT_MASK1, 8'h00, 1'b0, a);
      rd(7'h2c, d, a);
      `CHK("mask read", 8'h5a, d)
      rd(7'h2c, d, a);
      `CHK("mask reread", 8'h5a, d)
   endtask : t_default_addr

   task automatic t_events();
      sys_step();
      event_in = 16'h0003;
      sys_step();
      event_in = 16'h0000;
      repeat (3) sys_step();
      `CHK("masked events", 16'h0001, int_masked)
      wr(7'h2c, REG_INT_STATUS1, 8'h00, 1'b0, a);
      rd(7'h2c, d, a);
      `CHK("status1", 8'h03, d)
      `CHK("events after read", 16'h0000, int_masked)
   endtask : t_events

   task automatic t_temp();
      wr(7'h2c, REG_TEMP_CFG, 8'h05, 1'b1, a);
      `CHK("temp mode", 3'h5, temp_mode)
      wr(7'h2c, REG_TEMP_CFG, 8'h00, 1'b0, a);
      `CHK("temp after ptr", 3'h5, temp_mode)
      rd(7'h2c, d, a);
      `CHK("temp read", 8'h05, d)
   endtask : t_temp

   task automatic t_intrusion();
      sys_step();
      intrusion = 1'b1;
      repeat (4) sys_step();
      intrusion = 1'b0;
      repeat (4) sys_step();
      `CHK("intrusion set", 1'b1, latched)
      wr(7'h2c, REG_INTR_CLEAR, 8'h00, 1'b1, a);
      `CHK("intrusion clear", 1'b0, latched)
   endtask : t_intrusion

   task automatic t_upper();
      wr(7'h2c, REG_INT_MASK2, 8'h80, 1'b1, a);
      sys_step();
      event_in = 16'h8100;
      sys_step();
      event_in = 16'h0000;
      repeat (3) sys_step();
      `CHK("masked upper", 16'h0100, int_masked)
      wr(7'h2c, REG_INT_STATUS2, 8'h00, 1'b0, a);
      rd(7'h2c, d, a);
      `CHK("status2", 8'h81, d)
      `CHK("upper after read", 16'h0000, int_masked)
      wr(7'h2c, 8'h20, 8'hc3, 1'b1, a);
      wr(7'h2c, 8'h20, 8'h00, 1'b0, a);
      rd(7'h2c, d, a);
      `CHK("plain register", 8'hc3, d)
   endtask : t_upper

   task automatic t_readdress();
      do_reset(2'b11);
      `CHK("reset outputs", 20'h0_0000, {int_masked, latched, temp_mode})
      wr(7'h2c, REG_SERIAL_ADDR, 8'h00, 1'b0, a);
      `CHK("ack old straps", 1'b0, a)
      // Upper five bits 10010 sit in data[6:2]; the new address becomes 7'h4b.
      wr(7'h2f, REG_SERIAL_ADDR, 8'h48, 1'b1, a);
      `CHK("ack strapped", 1'b1, a)
      wr(7'h2f, REG_SERIAL_ADDR, 8'h00, 1'b0, a);
      `CHK("ack stale", 1'b0, a)
      wr(7'h4b, REG_SERIAL_ADDR, 8'h00, 1'b0, a);
      `CHK("ack new", 1'b1, a)
      rd(7'h4b, d, a);
      `CHK("addr read", 8'h4b, d)
      `CHK("ack read", 1'b1, a)
   endtask : t_readdress

   initial begin
      do_reset(2'b00);
      t_default_addr();
      t_events();
      t_temp();
      t_intrusion();
      t_upper();
      t_readdress();
      summarize();
   end

   // The sequence needs about half a millisecond of bus time.
   initial begin
      #3_000_000;
      fail_count++;
      summarize();
   end
endmodule : test_smbus_slave_register_port
